// ==== rtl/smo_consts.svh ====
// Constants for the signed min / multiply / negate / not-equal datapath.
// Assumes inclusion by bare name from rtl and tb files that need opcodes or latencies.
`ifndef SMO_CONSTS_SVH
`define SMO_CONSTS_SVH

// ---------------------------------------------------------------------------
// Operation codes
// ---------------------------------------------------------------------------
`define SMO_OPC_SUB 8'd13
`define SMO_OPC_MIN 8'd23
`define SMO_OPC_MUL_LO 8'd27
`define SMO_OPC_NEQ 8'd39
`define SMO_OPC_MUL_HI 8'd139

// ---------------------------------------------------------------------------
// Issue slot masks, bit n set when slot n may issue
// ---------------------------------------------------------------------------
`define SMO_SLOTS_ALU 8'h3e
`define SMO_SLOTS_DSP 8'h0a
`define SMO_SLOTS_MUL 8'h0c

// ---------------------------------------------------------------------------
// Latencies in clock cycles from the issue edge to the writeback strobe
// ---------------------------------------------------------------------------
`define SMO_LAT_ALU 1
`define SMO_LAT_DSP 2
`define SMO_LAT_MUL 3

// ---------------------------------------------------------------------------
// Fields and fixed values
// ---------------------------------------------------------------------------
`define SMO_ZERO_REGISTER 0
`define SMO_GUARD_BIT 0
`define SMO_MOST_NEG 32'h8000_0000

`endif

// ==== rtl/smo_pkg.sv ====
// Types shared by the datapath files.
// Assumes the word is 32 bits wide and register indices are 7 bits.
package smo_pkg;

  // Operand / result word
  typedef logic [31:0] smo_word_t;
  // Full product
  typedef logic [63:0] smo_prod_t;
  // Operation code
  typedef logic [7:0] smo_opc_t;

endpackage : smo_pkg

// ==== rtl/smo_mul.sv ====
// Two-stage signed 32x32 multiplier with a travelling tag.
// Assumes one clock, synchronous active-high reset, a new operand pair
// may be presented every cycle.
`timescale 1ns/10ps
`default_nettype none

module smo_mul #(
  parameter int DATA_W = 32,
  parameter int IDX_W = 7
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic in_valid,
  input wire logic in_hi,
  input wire logic [IDX_W-1:0] in_dest,
  input wire logic [DATA_W-1:0] in_a,
  input wire logic [DATA_W-1:0] in_b,
  output logic out_valid_q,
  output logic out_hi_q,
  output logic [IDX_W-1:0] out_dest_q,
  output logic [2*DATA_W-1:0] out_prod_q
);

  // ---------------------------------------------------------------------------
  // Stage one: operand capture
  // ---------------------------------------------------------------------------
  logic s1_valid_q; // Operands held
  logic s1_hi_q; // Upper word wanted
  logic [IDX_W-1:0] s1_dest_q; // Destination index
  logic [DATA_W-1:0] s1_a_q; // First operand
  logic [DATA_W-1:0] s1_b_q; // Second operand
  logic [2*DATA_W-1:0] prod_d; // Sign-extended product

  // Operands and tag
  always_ff @(posedge mclk) begin
    if (srst) begin
      s1_valid_q <= 1'b0;
      s1_hi_q <= 1'b0;
      s1_dest_q <= '0;
      s1_a_q <= '0;
      s1_b_q <= '0;
    end else begin
      s1_valid_q <= in_valid;
      s1_hi_q <= in_hi;
      s1_dest_q <= in_dest;
      s1_a_q <= in_a;
      s1_b_q <= in_b;
    end
  end

  // ---------------------------------------------------------------------------
  // Stage two: product
  // ---------------------------------------------------------------------------
  // [RQ2] Both operands sign-extended to full width
  assign prod_d = {{DATA_W{s1_a_q[DATA_W-1]}}, s1_a_q} * {{DATA_W{s1_b_q[DATA_W-1]}}, s1_b_q};

  // Product and tag
  always_ff @(posedge mclk) begin
    if (srst) begin
      out_valid_q <= 1'b0;
      out_hi_q <= 1'b0;
      out_dest_q <= '0;
      out_prod_q <= '0;
    end else begin
      out_valid_q <= s1_valid_q;
      out_hi_q <= s1_hi_q;
      out_dest_q <= s1_dest_q;
      out_prod_q <= prod_d;
    end
  end

endmodule : smo_mul

`default_nettype wire

// ==== rtl/smo_top.sv ====
// Datapath for signed minimum, signed multiply low/high, negate via
// subtract and not-equal compare, with guarded writeback strobes.
// Assumes issue/decode presents one operation per cycle with operand values
// already read; the register file consumes the three writeback channels.
//
// What this block does
// [RQ1] Minimum: smaller signed source, two cycles, slots 1,3
// [RQ2] Multiply low: low product word, three cycles
// [RQ3] Multiply low truncates silently, no flags
// [RQ4] Multiply high: upper product word, three cycles
// [RQ5] Negate is subtract from zero, one cycle
// [RQ6] Register zero always reads as zero
// [RQ7] Negating most negative value returns it unchanged
// [RQ8] Not-equal writes one or zero, one cycle
// [RQ9] False guard bit leaves destination unwritten
// [RQ10] No guard given means always write
`timescale 1ns/10ps
`default_nettype none
`include "smo_consts.svh"

module smo_top #(
  parameter int DATA_W = 32,
  parameter int IDX_W = 7
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic issue_valid,
  input wire logic [2:0] issue_slot,
  input wire logic [7:0] issue_opcode,
  input wire logic [IDX_W-1:0] first_source_register_idx,
  input wire logic [DATA_W-1:0] first_source_register_data,
  input wire logic [IDX_W-1:0] second_source_register_idx,
  input wire logic [DATA_W-1:0] second_source_register_data,
  input wire logic guard_given,
  input wire logic [DATA_W-1:0] guard_data,
  input wire logic [IDX_W-1:0] dest_idx,
  output logic alu_wb_valid_q,
  output logic [IDX_W-1:0] alu_wb_dest_q,
  output logic [DATA_W-1:0] alu_wb_data_q,
  output logic dsp_wb_valid_q,
  output logic [IDX_W-1:0] dsp_wb_dest_q,
  output logic [DATA_W-1:0] dsp_wb_data_q,
  output logic mul_wb_valid_q,
  output logic [IDX_W-1:0] mul_wb_dest_q,
  output logic [DATA_W-1:0] mul_wb_data_q,
  output logic slot_reject_q
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Slot legality against a mask
  function automatic logic slot_ok(input logic [7:0] mask, input logic [2:0] slot);
    slot_ok = mask[slot];
  endfunction : slot_ok

  // Signed full product of two words
  function automatic smo_pkg::smo_prod_t sx_mul(input smo_pkg::smo_word_t a,
                                                input smo_pkg::smo_word_t b);
    sx_mul = {{32{a[31]}}, a} * {{32{b[31]}}, b};
  endfunction : sx_mul

  // Upper or lower word of the signed full product
  function automatic smo_pkg::smo_word_t sx_mul_word(input smo_pkg::smo_word_t a,
      input smo_pkg::smo_word_t b, input logic hi);
    smo_pkg::smo_prod_t p;
    p = sx_mul(a, b);
    sx_mul_word = hi ? p[63:32] : p[31:0];
  endfunction : sx_mul_word

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  wire logic [DATA_W-1:0] src1; // First operand after zero forcing
  wire logic [DATA_W-1:0] src2; // Second operand after zero forcing
  wire logic guard_ok; // Writeback permitted
  wire logic live; // Issue taken this cycle
  wire logic is_sub; // Subtract / negate
  wire logic is_neq; // Not-equal compare
  wire logic is_min; // Signed minimum
  wire logic is_mlo; // Multiply low
  wire logic is_mhi; // Multiply high
  wire logic alu_go; // Legal ALU op
  wire logic dsp_go; // Legal DSP op
  wire logic mul_go; // Legal multiplier op
  wire logic bad_slot; // Known op in wrong slot
  wire logic [DATA_W-1:0] alu_res; // ALU result
  wire logic [DATA_W-1:0] min_res; // Minimum result

  // [RQ6] Index zero forced to zero
  assign src1 = (first_source_register_idx == IDX_W'(`SMO_ZERO_REGISTER)) ? '0
              : first_source_register_data;
  assign src2 = (second_source_register_idx == IDX_W'(`SMO_ZERO_REGISTER)) ? '0
              : second_source_register_data;
  // [RQ9] [RQ10] Guard bit or no guard
  assign guard_ok = !guard_given || guard_data[`SMO_GUARD_BIT];
  assign live = issue_valid && !srst;
  assign is_sub = issue_opcode == `SMO_OPC_SUB;
  assign is_neq = issue_opcode == `SMO_OPC_NEQ;
  assign is_min = issue_opcode == `SMO_OPC_MIN;
  assign is_mlo = issue_opcode == `SMO_OPC_MUL_LO;
  assign is_mhi = issue_opcode == `SMO_OPC_MUL_HI;
  assign alu_go = live && (is_sub || is_neq) && slot_ok(`SMO_SLOTS_ALU, issue_slot);
  assign dsp_go = live && is_min && slot_ok(`SMO_SLOTS_DSP, issue_slot);
  assign mul_go = live && (is_mlo || is_mhi) && slot_ok(`SMO_SLOTS_MUL, issue_slot);
  assign bad_slot = live && (is_sub || is_neq || is_min || is_mlo || is_mhi)
                  && !alu_go && !dsp_go && !mul_go;

  // [RQ5] [RQ7] Wrapping subtract, minimum negates to itself
  // [RQ8] Not-equal yields one or zero
  assign alu_res = is_neq ? DATA_W'(src1 != src2) : DATA_W'(src1 - src2);
  // [RQ1] Second source when first is greater
  assign min_res = ($signed(src1) > $signed(src2)) ? src2 : src1;

  // ---------------------------------------------------------------------------
  // ALU channel, one stage
  // ---------------------------------------------------------------------------
  // Result and strobe
  always_ff @(posedge mclk) begin
    if (srst) begin
      alu_wb_valid_q <= 1'b0;
      alu_wb_dest_q <= '0;
      alu_wb_data_q <= '0;
      slot_reject_q <= 1'b0;
    end else begin
      // [RQ9] Strobe only with true guard or no guard
      alu_wb_valid_q <= alu_go && guard_ok;
      alu_wb_dest_q <= dest_idx;
      alu_wb_data_q <= alu_res;
      slot_reject_q <= bad_slot;
    end
  end

  // ---------------------------------------------------------------------------
  // DSP channel, two stages
  // ---------------------------------------------------------------------------
  logic dsp1_valid_q; // First stage strobe
  logic [IDX_W-1:0] dsp1_dest_q; // First stage index
  logic [DATA_W-1:0] dsp1_data_q; // First stage result

  // Two registers deep for latency two
  always_ff @(posedge mclk) begin
    if (srst) begin
      dsp1_valid_q <= 1'b0;
      dsp1_dest_q <= '0;
      dsp1_data_q <= '0;
      dsp_wb_valid_q <= 1'b0;
      dsp_wb_dest_q <= '0;
      dsp_wb_data_q <= '0;
    end else begin
      // [RQ1] Guarded minimum
      dsp1_valid_q <= dsp_go && guard_ok;
      dsp1_dest_q <= dest_idx;
      dsp1_data_q <= min_res;
      dsp_wb_valid_q <= dsp1_valid_q;
      dsp_wb_dest_q <= dsp1_dest_q;
      dsp_wb_data_q <= dsp1_data_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Multiplier channel, three stages
  // ---------------------------------------------------------------------------
  wire logic mp_valid; // Product ready
  wire logic mp_hi; // Upper word wanted
  wire logic [IDX_W-1:0] mp_dest; // Destination index
  wire logic [2*DATA_W-1:0] mp_prod; // Full product
  wire logic [DATA_W-1:0] mp_word; // Selected word

  // Two pipeline stages inside
  smo_mul #(.DATA_W(DATA_W), .IDX_W(IDX_W)) u_mul (
    .mclk(mclk),
    .srst(srst),
    .in_valid(mul_go && guard_ok),
    .in_hi(is_mhi),
    .in_dest(dest_idx),
    .in_a(src1),
    .in_b(src2),
    .out_valid_q(mp_valid),
    .out_hi_q(mp_hi),
    .out_dest_q(mp_dest),
    .out_prod_q(mp_prod)
  );

  // [RQ2] [RQ4] Word select, [RQ3] no overflow flag
  assign mp_word = mp_hi ? mp_prod[2*DATA_W-1:DATA_W] : mp_prod[DATA_W-1:0];

  // Third stage output register
  always_ff @(posedge mclk) begin
    if (srst) begin
      mul_wb_valid_q <= 1'b0;
      mul_wb_dest_q <= '0;
      mul_wb_data_q <= '0;
    end else begin
      mul_wb_valid_q <= mp_valid;
      mul_wb_dest_q <= mp_dest;
      mul_wb_data_q <= mp_word;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  // Minimum lands two cycles later
  property p_min;
    @(posedge mclk) disable iff (srst)
    (dsp_go && guard_ok) |-> ##2 dsp_wb_valid_q
      && dsp_wb_data_q == (($signed($past(src1, 2)) > $signed($past(src2, 2)))
                           ? $past(src2, 2) : $past(src1, 2));
  endproperty
  a_min: assert property (p_min) else $error("minimum result wrong"); // [RQ1]

  // Low product three cycles later
  property p_mul_lo;
    @(posedge mclk) disable iff (srst)
    (mul_go && is_mlo && guard_ok) |-> ##3 mul_wb_valid_q
      && mul_wb_data_q == sx_mul_word($past(src1, 3), $past(src2, 3), 1'b0);
  endproperty
  a_mul_lo: assert property (p_mul_lo) else $error("low product wrong"); // [RQ2]

  // Overflowing product still written, never refused
  property p_mul_silent;
    @(posedge mclk) disable iff (srst)
    (mul_go && is_mlo && !guard_given) |=> !slot_reject_q ##2 mul_wb_valid_q;
  endproperty
  a_mul_silent: assert property (p_mul_silent) else $error("product not written"); // [RQ3]

  // High product three cycles later
  property p_mul_hi;
    @(posedge mclk) disable iff (srst)
    (mul_go && is_mhi && guard_ok) |-> ##3 mul_wb_valid_q
      && mul_wb_data_q == sx_mul_word($past(src1, 3), $past(src2, 3), 1'b1);
  endproperty
  a_mul_hi: assert property (p_mul_hi) else $error("high product wrong"); // [RQ4]

  // Negate from zero register in one cycle
  property p_neg;
    @(posedge mclk) disable iff (srst)
    (alu_go && is_sub && guard_ok
      && first_source_register_idx == IDX_W'(`SMO_ZERO_REGISTER))
      |=> alu_wb_valid_q && alu_wb_data_q == DATA_W'(~$past(src2) + 1'b1);
  endproperty
  a_neg: assert property (p_neg) else $error("negate result wrong"); // [RQ5]

  // Zero register reads zero even with data
  property p_zero_reg;
    @(posedge mclk) disable iff (srst)
    (alu_go && is_neq && guard_ok
      && first_source_register_idx == IDX_W'(`SMO_ZERO_REGISTER)
      && second_source_register_idx != IDX_W'(`SMO_ZERO_REGISTER))
      |=> alu_wb_data_q == DATA_W'($past(second_source_register_data) != '0);
  endproperty
  a_zero_reg: assert property (p_zero_reg) else $error("zero register not zero"); // [RQ6]

  // Most negative negates to itself
  property p_most_neg;
    @(posedge mclk) disable iff (srst)
    (alu_go && is_sub && guard_ok && src1 == '0 && src2 == `SMO_MOST_NEG)
      |=> alu_wb_data_q == `SMO_MOST_NEG;
  endproperty
  a_most_neg: assert property (p_most_neg) else $error("most negative negate wrong"); // [RQ7]

  // Not-equal compare
  property p_neq;
    @(posedge mclk) disable iff (srst)
    (alu_go && is_neq && guard_ok)
      |=> alu_wb_valid_q && alu_wb_data_q == DATA_W'($past(src1) != $past(src2));
  endproperty
  a_neq: assert property (p_neq) else $error("not-equal result wrong"); // [RQ8]

  // False guard suppresses every channel
  property p_guard_off;
    @(posedge mclk) disable iff (srst)
    (live && guard_given && !guard_data[`SMO_GUARD_BIT])
      |=> !alu_wb_valid_q ##1 !dsp_wb_valid_q ##1 !mul_wb_valid_q;
  endproperty
  a_guard_off: assert property (p_guard_off) else $error("write with false guard"); // [RQ9]

  // Unguarded ALU op always writes
  property p_no_guard;
    @(posedge mclk) disable iff (srst)
    (alu_go && !guard_given) |=> alu_wb_valid_q && alu_wb_dest_q == $past(dest_idx);
  endproperty
  a_no_guard: assert property (p_no_guard) else $error("unguarded op not written"); // [RQ10]

  // Main scenarios
  c_min: cover property (@(posedge mclk) disable iff (srst) dsp_go ##2 dsp_wb_valid_q);
  c_mul_hi: cover property (@(posedge mclk) disable iff (srst) mul_go && is_mhi);
  c_most_neg: cover property (@(posedge mclk) disable iff (srst)
    alu_go && is_sub && src1 == '0 && src2 == `SMO_MOST_NEG);
  c_reject: cover property (@(posedge mclk) disable iff (srst) bad_slot);

endmodule : smo_top

`default_nettype wire

// ==== tb/smo_issue_model.sv ====
// Behavioural model of the issue and decode logic feeding the datapath.
// Assumes one clock; every request is driven 1 ns after a rising edge.
`timescale 1ns/10ps
`default_nettype none

module smo_issue_model #(
  parameter int DATA_W = 32,
  parameter int IDX_W = 7
) (
  input wire logic mclk,
  output logic issue_valid,
  output logic [2:0] issue_slot,
  output logic [7:0] issue_opcode,
  output logic [IDX_W-1:0] first_source_register_idx,
  output logic [DATA_W-1:0] first_source_register_data,
  output logic [IDX_W-1:0] second_source_register_idx,
  output logic [DATA_W-1:0] second_source_register_data,
  output logic guard_given,
  output logic [DATA_W-1:0] guard_data,
  output logic [IDX_W-1:0] dest_idx
);
  // ---------------------------------------------------------------------------
  // Idle values at time zero
  // ---------------------------------------------------------------------------
  initial begin
    {issue_valid, issue_slot, issue_opcode, guard_given, guard_data} = '0;
    {first_source_register_idx, first_source_register_data} = '0;
    {second_source_register_idx, second_source_register_data, dest_idx} = '0;
  end

  // ---------------------------------------------------------------------------
  // Issue one operation
  // ---------------------------------------------------------------------------
  // Drive after an edge, hold through the taking edge, then release
  task automatic issue(input logic [7:0] opc, input logic [2:0] slot,
      input logic [IDX_W-1:0] i1, input logic [DATA_W-1:0] d1,
      input logic [IDX_W-1:0] i2, input logic [DATA_W-1:0] d2,
      input logic gg, input logic [DATA_W-1:0] gd, input logic [IDX_W-1:0] dst);
    @(posedge mclk);
    #1;
    issue_valid = 1'b1;
    {issue_opcode, issue_slot, guard_given, guard_data, dest_idx} = {opc, slot, gg, gd, dst};
    {first_source_register_idx, first_source_register_data} = {i1, d1};
    {second_source_register_idx, second_source_register_data} = {i2, d2};
    @(posedge mclk);
    #1;
    // Operand and guard data show the inverse; opcode, slot, indices, guard flag and destination keep their values
    issue_valid = 1'b0;
    first_source_register_data = ~d1;
    second_source_register_data = ~d2;
    guard_data = ~gd;
  endtask : issue
endmodule : smo_issue_model
`default_nettype wire

// ==== tb/tb_signed_min_mul_neg_cmp_ops.sv ====
// Self-checking bench for the min / multiply / negate / not-equal datapath.
// Assumes the issue model drives the datapath and outputs are read 1 ns after edges.
`timescale 1ns/10ps
`default_nettype none
`include "smo_consts.svh"

module tb_signed_min_mul_neg_cmp_ops;
  logic mclk, srst, issue_valid, guard_given;
  logic [2:0] issue_slot;
  logic [7:0] issue_opcode;
  logic [6:0] i1_idx, i2_idx, dest_idx, next_dest;
  logic [31:0] d1_data, d2_data, guard_data;
  logic alu_v, dsp_v, mul_v, slot_reject_q;
  logic [6:0] alu_d, dsp_d, mul_d;
  logic [31:0] alu_w, dsp_w, mul_w;
  int mismatches, n_tests;

  // ---------------------------------------------------------------------------
  // Clock, partner and datapath
  // ---------------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  smo_issue_model u_smo_issue_model (.mclk(mclk), .issue_valid(issue_valid),
    .issue_slot(issue_slot), .issue_opcode(issue_opcode),
    .first_source_register_idx(i1_idx), .first_source_register_data(d1_data),
    .second_source_register_idx(i2_idx), .second_source_register_data(d2_data),
    .guard_given(guard_given), .guard_data(guard_data), .dest_idx(dest_idx));

  smo_top u_smo_top (.mclk(mclk), .srst(srst), .issue_valid(issue_valid),
    .issue_slot(issue_slot), .issue_opcode(issue_opcode),
    .first_source_register_idx(i1_idx), .first_source_register_data(d1_data),
    .second_source_register_idx(i2_idx), .second_source_register_data(d2_data),
    .guard_given(guard_given), .guard_data(guard_data), .dest_idx(dest_idx),
    .alu_wb_valid_q(alu_v), .alu_wb_dest_q(alu_d), .alu_wb_data_q(alu_w),
    .dsp_wb_valid_q(dsp_v), .dsp_wb_dest_q(dsp_d), .dsp_wb_data_q(dsp_w),
    .mul_wb_valid_q(mul_v), .mul_wb_dest_q(mul_d), .mul_wb_data_q(mul_w),
    .slot_reject_q(slot_reject_q));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  // Word comparison, counted
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Issue one op, verify silence before the latency and the write at it
  task automatic run_op(input logic [7:0] opc, input logic [2:0] slot, input logic [6:0] i1,
      input logic [31:0] d1, input logic [31:0] d2, input logic gg, input logic [31:0] gd,
      input int ch, input logic expv, input logic [31:0] expd);
    int lat;
    logic v;
    logic [6:0] d;
    logic [31:0] w;
    lat = (ch == 0) ? `SMO_LAT_ALU : (ch == 1) ? `SMO_LAT_DSP : `SMO_LAT_MUL;
    next_dest = next_dest + 7'h01;
    u_smo_issue_model.issue(opc, slot, i1, d1, 7'h22, d2, gg, gd, next_dest);
    for (int k = 1; k <= lat; k++) begin
      if (k > 1) begin
        @(posedge mclk);
        #1;
      end
      // No status of any kind for a legal op
      if (k == 1) check({31'h0, slot_reject_q}, 32'h0);
      {v, d, w} = (ch == 0) ? {alu_v, alu_d, alu_w} :
                  (ch == 1) ? {dsp_v, dsp_d, dsp_w} : {mul_v, mul_d, mul_w};
      if (k < lat) check({31'h0, v}, 32'h0);
    end
    check({31'h0, v}, {31'h0, expv});
    if (expv) begin
      check({25'h0, d}, {25'h0, next_dest});
      check(w, expd);
    end
  endtask : run_op

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Minimum over signed boundaries, both legal slots
  task automatic t_min();
    logic [31:0] a[5] = '{32'h2, 32'h100, 32'hffffff00, 32'h7fffffff, 32'h5};
    logic [31:0] b[5] = '{32'h1, 32'hffffff9c, 32'hffffff9c, 32'h80000000, 32'h5};
    logic [31:0] e[5] = '{32'h1, 32'hffffff9c, 32'hffffff00, 32'h80000000, 32'h5};
    for (int i = 0; i < 5; i++) begin
      run_op(`SMO_OPC_MIN, (i % 2) ? 3'd3 : 3'd1, 7'h11, a[i], b[i], 1'b0, 32'h0, 1, 1'b1, e[i]);
    end
    $display("test min done");
  endtask : t_min

  // Low and high product words, silent truncation
  task automatic t_mul();
    logic [7:0] o[6] = '{`SMO_OPC_MUL_LO, `SMO_OPC_MUL_LO, `SMO_OPC_MUL_LO,
                         `SMO_OPC_MUL_HI, `SMO_OPC_MUL_HI, `SMO_OPC_MUL_HI};
    logic [31:0] a[6] = '{32'h100, 32'hffffff00, 32'h10001000, 32'h10000, 32'h10001000,
                          32'hffffff00};
    logic [31:0] b[6] = '{32'h100, 32'hffffff9c, 32'hf1100000, 32'h10000, 32'hf1100000,
                          32'h64};
    logic [31:0] e[6] = '{32'h10000, 32'h6400, 32'h0, 32'h1, 32'hff10ff11, 32'hffffffff};
    for (int i = 0; i < 6; i++) begin
      run_op(o[i], (i % 2) ? 3'd3 : 3'd2, 7'h12, a[i], b[i], 1'b0, 32'h0, 2, 1'b1, e[i]);
    end
    $display("test mul done");
  endtask : t_mul

  // Negate through subtract from the zero register, ALU slots 1 to 5, then one plain subtract in slot 4
  task automatic t_neg();
    logic [31:0] s[5] = '{32'hffffffff, 32'hfffffff4, 32'h80000001, 32'h80000000, 32'h1};
    logic [31:0] e[5] = '{32'h1, 32'hc, 32'h7fffffff, 32'h80000000, 32'hffffffff};
    for (int i = 0; i < 5; i++) begin
      run_op(`SMO_OPC_SUB, 3'(i + 1), 7'h00, 32'h1234abcd, s[i], 1'b0, 32'h0, 0, 1'b1, e[i]);
    end
    run_op(`SMO_OPC_SUB, 3'd4, 7'h13, 32'h3, 32'h4, 1'b0, 32'h0, 0, 1'b1, 32'hffffffff);
    $display("test neg done");
  endtask : t_neg

  // Not-equal on differing and equal pairs
  task automatic t_neq();
    run_op(`SMO_OPC_NEQ, 3'd1, 7'h14, 32'h3, 32'h4, 1'b0, 32'h0, 0, 1'b1, 32'h1);
    run_op(`SMO_OPC_NEQ, 3'd5, 7'h14, 32'h1000, 32'h1000, 1'b0, 32'h0, 0, 1'b1, 32'h0);
    run_op(`SMO_OPC_NEQ, 3'd2, 7'h14, 32'h80000000, 32'h4, 1'b0, 32'h0, 0, 1'b1, 32'h1);
    run_op(`SMO_OPC_NEQ, 3'd3, 7'h00, 32'h5, 32'h0, 1'b0, 32'h0, 0, 1'b1, 32'h0);
    $display("test neq done");
  endtask : t_neq

  // Guard bit zero blocks, bit one writes, absent guard writes
  task automatic t_guard();
    run_op(`SMO_OPC_MIN, 3'd1, 7'h15, 32'h100, 32'h2, 1'b1, 32'h0, 1, 1'b0, 32'h0);
    run_op(`SMO_OPC_MUL_LO, 3'd2, 7'h15, 32'h100, 32'hf11, 1'b1, 32'hfffffffe, 2, 1'b0, 32'h0);
    run_op(`SMO_OPC_MUL_HI, 3'd3, 7'h15, 32'h100, 32'hf11, 1'b1, 32'h2, 2, 1'b0, 32'h0);
    run_op(`SMO_OPC_SUB, 3'd4, 7'h00, 32'h0, 32'hfffffff4, 1'b1, 32'h0, 0, 1'b0, 32'h0);
    run_op(`SMO_OPC_NEQ, 3'd5, 7'h15, 32'h1000, 32'h3, 1'b1, 32'h0, 0, 1'b0, 32'h0);
    run_op(`SMO_OPC_MUL_LO, 3'd2, 7'h15, 32'h100, 32'hf11, 1'b1, 32'h3, 2, 1'b1, 32'hf1100);
    run_op(`SMO_OPC_SUB, 3'd1, 7'h00, 32'h0, 32'hfffffff4, 1'b1, 32'h1, 0, 1'b1, 32'hc);
    run_op(`SMO_OPC_MIN, 3'd3, 7'h15, 32'h100, 32'h2, 1'b0, 32'h0, 1, 1'b1, 32'h2);
    $display("test guard done");
  endtask : t_guard

  // Wrong slots refused with a pulse and no write, unknown opcode ignored
  task automatic t_reject();
    logic [7:0] o[3] = '{`SMO_OPC_MIN, `SMO_OPC_MUL_HI, 8'h00};
    logic [2:0] s[3] = '{3'd2, 3'd5, 3'd1};
    for (int i = 0; i < 3; i++) begin
      u_smo_issue_model.issue(o[i], s[i], 7'h16, 32'h5, 7'h22, 32'h3, 1'b0, 32'h0, 7'h40);
      check({31'h0, slot_reject_q}, (i < 2) ? 32'h1 : 32'h0);
      check({31'h0, alu_v}, 32'h0);
      repeat (2) begin
        @(posedge mclk);
        #1;
        check({31'h0, dsp_v | mul_v}, 32'h0);
      end
    end
    $display("test reject done");
  endtask : t_reject

  // ---------------------------------------------------------------------------
  // Verdict and main sequence
  // ---------------------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    srst = 1'b1;
    next_dest = 7'h00;
    mismatches = 0;
    n_tests = 0;
    repeat (12) @(posedge mclk);
    #1;
    srst = 1'b0;
    t_min();
    t_mul();
    t_neg();
    t_neq();
    t_guard();
    t_reject();
    end_of_test();
  end
endmodule : tb_signed_min_mul_neg_cmp_ops
`default_nettype wire
